// ==== rtl/apsp_pkg.sv ====
package apsp_pkg;

  // Data width select codes {width_sel_hi, width_sel_lo}
  localparam logic [1:0] WSEL_16_F32 = 2'h0;
  localparam logic [1:0] WSEL_16_F64 = 2'h1;
  localparam logic [1:0] WSEL_32     = 2'h2;
  localparam logic [1:0] WSEL_24     = 2'h3;

  // Audio protocol select codes
  localparam logic [1:0] PROTO_I2S = 2'h0;
  localparam logic [1:0] PROTO_LJ  = 2'h1;
  localparam logic [1:0] PROTO_RJ  = 2'h2;
  localparam logic [1:0] PROTO_PCM = 2'h3;

  // Word and FIFO geometry
  localparam int         WORD_W     = 32;
  localparam int         FIFO_DEPTH = 8;
  localparam logic [3:0] DEPTH_16   = 4'h8;
  localparam logic [3:0] DEPTH_32   = 4'h4;
  localparam logic [3:0] DEPTH_STD  = 4'h1;

  // Bit counts
  localparam logic [5:0] LEN_16     = 6'h10;
  localparam logic [5:0] LEN_24     = 6'h18;
  localparam logic [5:0] LEN_32     = 6'h20;
  localparam logic [5:0] CH_BITS_32 = 6'h10;
  localparam logic [5:0] CH_BITS_64 = 6'h20;
  localparam logic [5:0] CNT_MAX    = 6'h3f;

  // Byte lanes in use and the lane holding the top byte
  localparam logic [3:0] BE_USED_16 = 4'h3;
  localparam logic [3:0] BE_USED_24 = 4'h7;
  localparam logic [3:0] BE_USED_32 = 4'hf;
  localparam logic [3:0] BE_TOP_16  = 4'h2;
  localparam logic [3:0] BE_TOP_24  = 4'h4;
  localparam logic [3:0] BE_TOP_32  = 4'h8;

  // Quasi-static configuration carried into the bit clock domain
  typedef struct packed {
    logic       active;
    logic       master;
    logic       fpol;
    logic       fe_en;
    logic       pcm;
    logic [1:0] wsel;
  } apsp_cfg_t;

  // Software write to the data buffer port
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  be;
  } apsp_wr_t;

  function automatic logic [5:0] apsp_data_len(input logic [1:0] w);
    return (w == WSEL_24) ? LEN_24 : (w == WSEL_32) ? LEN_32 : LEN_16;
  endfunction

  function automatic logic [5:0] apsp_ch_bits(input logic [1:0] w);
    return (w == WSEL_16_F32) ? CH_BITS_32 : CH_BITS_64;
  endfunction

  function automatic logic [3:0] apsp_be_used(input logic [1:0] w);
    return (w == WSEL_24) ? BE_USED_24 : (w == WSEL_32) ? BE_USED_32 : BE_USED_16;
  endfunction

  function automatic logic [3:0] apsp_be_top(input logic [1:0] w);
    return (w == WSEL_24) ? BE_TOP_24 : (w == WSEL_32) ? BE_TOP_32 : BE_TOP_16;
  endfunction

  function automatic logic [3:0] apsp_depth(input logic [1:0] w, input logic enh);
    if (!enh) return DEPTH_STD;
    return (w[1]) ? DEPTH_32 : DEPTH_16;
  endfunction

  // Left-align a right-aligned sample for MSB-first shifting
  function automatic logic [31:0] apsp_align(input logic [31:0] d, input logic [1:0] w);
    if (w == WSEL_32) return d;
    if (w == WSEL_24) return {d[23:0], 8'h00};
    return {d[15:0], 16'h0000};
  endfunction

endpackage

// ==== rtl/apsp_fifo.sv ====
module apsp_fifo
  import apsp_pkg::*;
#(
  parameter int W = 32,
  parameter int D = 8
) (
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire logic                   flush,
  input  wire logic [$clog2(D+1)-1:0] limit,
  input  wire logic                   push,
  input  wire logic [W-1:0]           push_data,
  input  wire logic                   pop,
  output logic      [W-1:0]           pop_data,
  output logic                        full,
  output logic                        empty
);
  localparam int CW = $clog2(D + 1);
  localparam int PW = $clog2(D);

  if (D < 2 || W < 1) begin : g_bad_geom
    $error("apsp_fifo: depth below 2 or zero width");
  end

  logic [W-1:0]  mem [D];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [PW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] count_reg, count_next;
  logic [W-1:0]  pop_data_reg, pop_data_next;
  logic          do_push, do_pop;

  // Depth is the selected limit; full does not check it against the storage
  assign full     = (count_reg >= limit);
  assign empty    = (count_reg == '0);
  assign do_push  = push & ~full;
  assign do_pop   = pop & ~empty;
  assign pop_data = pop_data_reg;

  // Pointer and count update
  always_comb begin
    wr_ptr_next   = wr_ptr_reg;
    rd_ptr_next   = rd_ptr_reg;
    count_next    = count_reg;
    pop_data_next = pop_data_reg;
    if (do_push) begin
      wr_ptr_next = (wr_ptr_reg == PW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (do_pop) begin
      rd_ptr_next   = (rd_ptr_reg == PW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
      pop_data_next = mem[rd_ptr_reg];
    end
    count_next = count_reg + CW'(do_push) - CW'(do_pop);
    if (flush) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next  = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      pop_data_reg <= '0;
    end else begin
      wr_ptr_reg   <= wr_ptr_next;
      rd_ptr_reg   <= rd_ptr_next;
      count_reg    <= count_next;
      pop_data_reg <= pop_data_next;
    end
  end

  // Storage, no reset
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  a_fifo_limit : assert property (@(posedge clk_sys) disable iff (!resetn)
    (count_reg <= limit) || $past(flush) || $changed(limit))
    else $error("fifo count above selected depth");

endmodule

// ==== rtl/apsp_audio_port.sv ====
// Functional notes
// - Sample lengths are 16, 24 or 32 bits
// - 16-bit data: 16-wide, 8-deep FIFO, 32/64 frame; the FIFO is built 32 wide for every data length
// - 24/32-bit data: 32-wide, 4-deep FIFO, 64 frame
// - Written bytes above the data length are dropped
// - Top byte write of sample pushes the FIFO
// - Writes to unused bytes only never push
// - Early channel edge: flag, push rx, reload tx; rx is not pushed in PCM mode
// - Frame error detection gated by enable bit
// - Early edge resyncs; non-PCM pushes shortened data
// - Two-bit field names four protocols; only PCM (11) is decoded
// - MSB first, zero fill to frame end
// - Master frame is exactly 32 or 64 clocks
// - Slave accepts long frames, flags early edges
// - MSB out first falling, sampled second rising
// - Left while word clock low, right while high
// - Output changes falling, input sampled rising
// - Transmit and receive run in full duplex
// - Enhanced buffer bit picks FIFO or single buffer
// - Slave starts only on master's clocks
// - Protocol code 01 is left-justified
// - Master generates clocks continuously while enabled
// - Empty transmit FIFO sends zeros
module apsp_audio_port
  import apsp_pkg::*;
#(
  parameter logic [7:0] BCLK_HALF_DIV = 8'h04
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        bit_clk,
  input  wire logic        module_en,
  input  wire logic        audio_enable,
  input  wire logic        master_select,
  input  wire logic        frame_polarity,
  input  wire logic        clock_polarity,
  input  wire logic [1:0]  audio_protocol_sel,
  input  wire logic        width_sel_hi,
  input  wire logic        width_sel_lo,
  input  wire logic        frame_error_detect_en,
  input  wire logic        enhanced_buffer_en,
  input  wire logic        wr_stb,
  input  wire apsp_wr_t    wr_in,
  input  wire logic        rd_stb,
  output logic      [31:0] rd_data,
  output logic             rd_valid,
  output logic             tx_full,
  output logic             tx_empty,
  output logic             rx_full,
  output logic             rx_empty,
  output logic             frame_error_flag,
  input  wire logic        frame_error_clr,
  output logic             rx_overflow_flag,
  input  wire logic        rx_overflow_clr,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             bclk_o,
  output logic             bclk_oe_n,
  input  wire logic        wclk_i,
  output logic             wclk_o,
  output logic             wclk_oe_n
);

  if (BCLK_HALF_DIV == 8'h00) begin : g_bad_div
    $error("apsp_audio_port: bit clock divider must be at least 1");
  end

  // ---------------- System clock domain ----------------
  apsp_cfg_t   cfg;
  logic [3:0]  be_used, fifo_limit;
  logic [31:0] merged;
  logic        wr_take, tx_push, tx_pop, rx_push, rx_pop, hold_busy;
  logic [31:0] tx_rdata;
  logic [31:0] part_reg, part_next;
  logic [31:0] hold_reg, hold_next;
  logic        pend_reg, pend_next, send_tgl_reg, send_tgl_next;
  logic        ack_m1, ack_m2, rxt_m1, rxt_m2, rxt_m3, fet_m1, fet_m2, fet_m3;
  logic        ovf_reg, ovf_next, fe_reg, fe_next, rdv_reg, rdv_next;
  logic [7:0]  div_reg, div_next;
  logic        bclk_reg, bclk_next, bclk_run;
  // Link side state read across the boundary
  logic        ack_tgl_reg, rx_tgl_reg, fe_tgl_reg;
  logic [31:0] rx_hold_reg;

  // Only the PCM decode of the protocol field is held for the link; all modes use the same edge plan
  assign cfg = '{active: module_en & audio_enable, master: master_select,
                 fpol: frame_polarity, fe_en: frame_error_detect_en,
                 pcm: (audio_protocol_sel == PROTO_PCM),
                 wsel: {width_sel_hi, width_sel_lo}};

  // Byte lanes kept for the selected data length
  assign be_used    = wr_in.be & apsp_be_used(cfg.wsel);
  assign wr_take    = wr_stb & cfg.active & (|be_used);
  assign fifo_limit = apsp_depth(cfg.wsel, enhanced_buffer_en);

  // Byte packing of partial writes
  always_comb begin
    merged    = part_reg;
    part_next = part_reg;
    tx_push   = 1'b0;
    for (int b = 0; b < 4; b++) begin
      if (be_used[b]) begin
        merged[8*b +: 8] = wr_in.data[8*b +: 8];
      end
    end
    if (wr_take) begin
      part_next = merged;
      if (|(be_used & apsp_be_top(cfg.wsel))) begin
        tx_push   = 1'b1;
        part_next = '0;
      end
    end
    if (!cfg.active) begin
      part_next = '0;
    end
  end

  apsp_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_tx_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .flush     (~cfg.active),
    .limit     (fifo_limit),
    .push      (tx_push),
    .push_data (merged),
    .pop       (tx_pop),
    .pop_data  (tx_rdata),
    .full      (tx_full),
    .empty     (tx_empty)
  );

  // Hold word handed to the link by a toggle handshake
  assign hold_busy = send_tgl_reg ^ ack_m2;
  assign tx_pop    = ~hold_busy & ~pend_reg & ~tx_empty;
  always_comb begin
    pend_next     = tx_pop;
    hold_next     = hold_reg;
    send_tgl_next = send_tgl_reg;
    if (pend_reg) begin
      hold_next     = tx_rdata;
      send_tgl_next = ~send_tgl_reg;
    end
  end

  // Receive push, overflow and frame error status
  assign rx_push = rxt_m2 ^ rxt_m3;
  assign rx_pop  = rd_stb & ~rx_empty;
  always_comb begin
    ovf_next = ovf_reg;
    fe_next  = fe_reg;
    rdv_next = rx_pop;
    if (rx_overflow_clr) begin
      ovf_next = 1'b0;
    end
    if (rx_push & rx_full) begin
      ovf_next = 1'b1;
    end
    if (frame_error_clr) begin
      fe_next = 1'b0;
    end
    if (fet_m2 ^ fet_m3) begin
      fe_next = 1'b1;
    end
  end

  apsp_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_rx_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .flush     (~cfg.active),
    .limit     (fifo_limit),
    .push      (rx_push),
    .push_data (rx_hold_reg),
    .pop       (rx_pop),
    .pop_data  (rd_data),
    .full      (rx_full),
    .empty     (rx_empty)
  );

  // Bit clock divider, free running while master and enabled
  assign bclk_run = cfg.active & cfg.master;
  always_comb begin
    div_next  = div_reg;
    bclk_next = bclk_reg;
    if (!bclk_run) begin
      div_next  = '0;
      bclk_next = 1'b0;
    end else if (div_reg == BCLK_HALF_DIV - 8'h01) begin
      div_next  = '0;
      bclk_next = ~bclk_reg;
    end else begin
      div_next = div_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      part_reg     <= '0;
      hold_reg     <= '0;
      pend_reg     <= 1'b0;
      send_tgl_reg <= 1'b0;
      ovf_reg      <= 1'b0;
      fe_reg       <= 1'b0;
      rdv_reg      <= 1'b0;
      div_reg      <= '0;
      bclk_reg     <= 1'b0;
      {ack_m1, ack_m2}         <= 2'h0;
      {rxt_m1, rxt_m2, rxt_m3} <= 3'h0;
      {fet_m1, fet_m2, fet_m3} <= 3'h0;
    end else begin
      part_reg     <= part_next;
      hold_reg     <= hold_next;
      pend_reg     <= pend_next;
      send_tgl_reg <= send_tgl_next;
      ovf_reg      <= ovf_next;
      fe_reg       <= fe_next;
      rdv_reg      <= rdv_next;
      div_reg      <= div_next;
      bclk_reg     <= bclk_next;
      {ack_m1, ack_m2}         <= {ack_tgl_reg, ack_m1};
      {rxt_m1, rxt_m2, rxt_m3} <= {rx_tgl_reg, rxt_m1, rxt_m2};
      {fet_m1, fet_m2, fet_m3} <= {fe_tgl_reg, fet_m1, fet_m2};
    end
  end

  assign rd_valid         = rdv_reg;
  assign frame_error_flag = fe_reg;
  assign rx_overflow_flag = ovf_reg;
  assign bclk_o           = bclk_run ? bclk_reg : clock_polarity;
  assign bclk_oe_n        = ~bclk_run;
  assign wclk_oe_n        = ~bclk_run;

  a_fe_sticky : assert property (@(posedge clk_sys) disable iff (!resetn)
    fe_reg && !frame_error_clr |=> fe_reg)
    else $error("frame error flag dropped without a clear");

  a_top_push : assert property (@(posedge clk_sys) disable iff (!resetn)
    tx_push |-> wr_stb && (wr_in.be & apsp_be_top(cfg.wsel)) != 4'h0)
    else $error("transmit push without top byte write");

  a_unused_ignored : assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_stb && cfg.active && (wr_in.be & apsp_be_used(cfg.wsel)) == 4'h0
    |-> !tx_push ##1 part_reg == $past(part_reg))
    else $error("write to unused bytes changed transmit state");

  // ---------------- Bit clock domain ----------------
  apsp_cfg_t   cfg_l1, cfg_l2;
  logic        lrst_1, link_rst_n, sendt_l1, sendt_l2;
  logic        ws_raw, ws_eff, ch_start, early;
  logic [5:0]  len_l, chb_l;
  logic        started_reg, started_next, ws_prev_reg, ws_prev_next;
  logic [5:0]  cnt_reg, cnt_next, mcnt_reg, mcnt_next;
  logic [31:0] tb_reg, tb_next, tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next;
  logic        tb_full_reg, tb_full_next, ack_tgl_next, rx_tgl_next, fe_tgl_next;
  logic [31:0] rx_hold_next, rx_word;
  logic        ws_gen_reg, ws_gen_next, sdo_reg, sdo_next;

  // Link reset release aligned to the bit clock
  always_ff @(posedge bit_clk or negedge resetn) begin
    if (!resetn) begin
      {lrst_1, link_rst_n} <= 2'h0;
    end else begin
      {lrst_1, link_rst_n} <= {1'b1, lrst_1};
    end
  end

  assign len_l    = apsp_data_len(cfg_l2.wsel);
  assign chb_l    = apsp_ch_bits(cfg_l2.wsel);
  assign ws_raw   = cfg_l2.master ? ws_gen_reg : wclk_i;
  assign ws_eff   = ws_raw ^ cfg_l2.fpol;
  assign ch_start = ws_eff ^ ws_prev_reg;
  assign early    = started_reg & ch_start & (cnt_reg < chb_l - 6'h01);
  assign rx_word  = (cnt_reg < len_l) ? {rx_sh_reg[30:0], sdi} : rx_sh_reg;

  // Channel framing, shifting and buffer exchange
  always_comb begin
    started_next = started_reg;
    ws_prev_next = ws_eff;
    cnt_next     = cnt_reg;
    tb_next      = tb_reg;
    tb_full_next = tb_full_reg;
    tx_sh_next   = tx_sh_reg;
    rx_sh_next   = rx_sh_reg;
    ack_tgl_next = ack_tgl_reg;
    rx_tgl_next  = rx_tgl_reg;
    fe_tgl_next  = fe_tgl_reg;
    rx_hold_next = rx_hold_reg;
    if (!cfg_l2.active) begin
      started_next = 1'b0;
      cnt_next     = '0;
      tb_full_next = 1'b0;
      tx_sh_next   = '0;
      rx_sh_next   = '0;
    end else if (ch_start && (started_reg || !ws_eff)) begin
      if (started_reg && (!early || !cfg_l2.pcm)) begin
        rx_hold_next = rx_word;
        rx_tgl_next  = ~rx_tgl_reg;
      end
      if (early && cfg_l2.fe_en) begin
        fe_tgl_next = ~fe_tgl_reg;
      end
      started_next = 1'b1;
      cnt_next     = '0;
      rx_sh_next   = '0;
      tx_sh_next   = tb_full_reg ? apsp_align(tb_reg, cfg_l2.wsel) : '0;
      tb_full_next = 1'b0;
    end else if (started_reg) begin
      cnt_next   = (cnt_reg == CNT_MAX) ? CNT_MAX : cnt_reg + 6'h01;
      tx_sh_next = {tx_sh_reg[30:0], 1'b0};
      if (cnt_reg < len_l) begin
        rx_sh_next = {rx_sh_reg[30:0], sdi};
      end
    end
    if (cfg_l2.active && !tb_full_reg && (sendt_l2 ^ ack_tgl_reg)) begin
      tb_next      = hold_reg;
      tb_full_next = 1'b1;
      ack_tgl_next = ~ack_tgl_reg;
    end
  end

  // Master half-frame counter
  always_comb begin
    mcnt_next = '0;
    if (cfg_l2.active && cfg_l2.master && mcnt_reg != chb_l - 6'h01) begin
      mcnt_next = mcnt_reg + 6'h01;
    end
  end

  always_ff @(posedge bit_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cfg_l1      <= '0;
      cfg_l2      <= '0;
      sendt_l1    <= 1'b0;
      sendt_l2    <= 1'b0;
      started_reg <= 1'b0;
      ws_prev_reg <= 1'b0;
      cnt_reg     <= '0;
      mcnt_reg    <= '0;
      tb_reg      <= '0;
      tb_full_reg <= 1'b0;
      tx_sh_reg   <= '0;
      rx_sh_reg   <= '0;
      ack_tgl_reg <= 1'b0;
      rx_tgl_reg  <= 1'b0;
      fe_tgl_reg  <= 1'b0;
      rx_hold_reg <= '0;
    end else begin
      cfg_l1      <= cfg;
      cfg_l2      <= cfg_l1;
      sendt_l1    <= send_tgl_reg;
      sendt_l2    <= sendt_l1;
      started_reg <= started_next;
      ws_prev_reg <= ws_prev_next;
      cnt_reg     <= cnt_next;
      mcnt_reg    <= mcnt_next;
      tb_reg      <= tb_next;
      tb_full_reg <= tb_full_next;
      tx_sh_reg   <= tx_sh_next;
      rx_sh_reg   <= rx_sh_next;
      ack_tgl_reg <= ack_tgl_next;
      rx_tgl_reg  <= rx_tgl_next;
      fe_tgl_reg  <= fe_tgl_next;
      rx_hold_reg <= rx_hold_next;
    end
  end

  // Falling edge: word clock and serial output change
  always_comb begin
    ws_gen_next = ws_gen_reg;
    if (cfg_l2.active && cfg_l2.master && mcnt_reg == chb_l - 6'h01) begin
      ws_gen_next = ~ws_gen_reg;
    end
    sdo_next = started_reg ? tx_sh_reg[31] : 1'b0;
  end

  always_ff @(negedge bit_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ws_gen_reg <= 1'b1;
      sdo_reg    <= 1'b0;
    end else begin
      ws_gen_reg <= ws_gen_next;
      sdo_reg    <= sdo_next;
    end
  end

  assign sdo    = sdo_reg;
  assign wclk_o = ws_gen_reg;

  a_early_flag : assert property (@(posedge bit_clk) disable iff (!link_rst_n)
    early && cfg_l2.active && cfg_l2.fe_en |=> fe_tgl_reg != $past(fe_tgl_reg))
    else $error("early channel edge did not raise frame error");

  a_no_flag_ok : assert property (@(posedge bit_clk) disable iff (!link_rst_n)
    !early || !cfg_l2.fe_en |=> $stable(fe_tgl_reg))
    else $error("frame error raised without an early edge");

  a_zero_empty : assert property (@(posedge bit_clk) disable iff (!link_rst_n)
    cfg_l2.active && ch_start && !ws_eff && !tb_full_reg |=> tx_sh_reg == 32'h0)
    else $error("empty transmit buffer did not send zeros");

  a_start_left : assert property (@(posedge bit_clk) disable iff (!link_rst_n)
    $rose(started_reg) |-> ws_prev_reg == 1'b0 && $past(ws_prev_reg) == 1'b1)
    else $error("link started on a word clock edge other than left");

  a_ws_half : assert property (@(posedge bit_clk) disable iff (!link_rst_n)
    cfg_l2.active && cfg_l2.master && $past(cfg_l2.active) && mcnt_reg == chb_l - 6'h01
    |-> ws_gen_reg != $past(ws_gen_reg) ##1 ws_gen_reg == $past(ws_gen_reg))
    else $error("master word clock not toggled at half frame");

  a_msb_load : assert property (@(posedge bit_clk) disable iff (!link_rst_n)
    cfg_l2.active && ch_start && started_reg && tb_full_reg
    |=> tx_sh_reg == apsp_align($past(tb_reg), cfg_l2.wsel)
    ##1 (tx_sh_reg == {$past(tx_sh_reg[30:0]), 1'b0} || $past(ch_start) || !$past(cfg_l2.active)))
    else $error("transmit word not shifted MSB first with zero fill");

endmodule

// ==== verif/apsp_codec_model.sv ====
module apsp_codec_model (
  output logic             bit_clk,
  output logic             wclk,
  output logic             sdi,
  input  wire logic        sdo,
  input  wire logic        run,
  input  wire logic [5:0]  ch_len,
  input  wire logic [31:0] tx_word,
  output logic      [15:0] rx_l,
  output logic      [15:0] rx_r
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [5:0]  cnt;
  logic [15:0] sh;

  // Bit clock, 48 ns, parks high while stopped
  initial begin
    bit_clk = 1'b1;
    forever begin
      #24;
      if (run || !bit_clk) bit_clk = ~bit_clk;
    end
  end

  // Word clock one bit ahead of data, data MSB first on falling edges
  initial begin
    {cnt, wclk, sdi, sh, rx_l, rx_r} = {6'h0, 1'b1, 1'b0, 48'h0};
  end
  always @(negedge bit_clk) begin
    if (cnt >= ch_len - 6'h1) begin
      if (wclk) rx_l = sh;
      else rx_r = sh;
    end
    cnt = (cnt >= ch_len - 6'h1) ? 6'h0 : cnt + 6'h1;
    if (cnt == ch_len - 6'h1) wclk = ~wclk;
    sdi = tx_word[4'hf - cnt[3:0]] ^ wclk ^ (cnt == ch_len - 6'h1); // Right is inverted
  end

  // Capture device output on rising edges
  always @(posedge bit_clk) begin
    sh[4'hf - cnt[3:0]] = sdo;
  end
endmodule

// ==== verif/audio_protocol_serial_port_tb.sv ====
module audio_protocol_serial_port_tb;
  import apsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys, resetn, bit_clk, wclk, sdi, sdo, run, rd_valid, tx_empty, rx_empty;
  logic        module_en, audio_enable, width_sel_lo, frame_error_detect_en, frame_error_flag;
  logic        enhanced_buffer_en, wr_stb, rd_stb, frame_error_clr, rx_overflow_clr;
  logic        master_select, cbclk, tx_full, rx_full, rx_overflow_flag;
  logic        bclk_o, bclk_oe_n, wclk_o, wclk_oe_n;
  logic [31:0] rd_data, tx_word, smp, got;
  logic [15:0] rx_l, rx_r;
  logic [5:0]  ch_len;
  apsp_wr_t    wr_in;
  int          errors, checks, seed;

  apsp_audio_port dut (
    .clk_sys, .resetn, .bit_clk, .module_en, .audio_enable,
    .master_select, .frame_polarity(1'b0), .clock_polarity(1'b1),
    .audio_protocol_sel(2'h0), .width_sel_hi(1'b0), .width_sel_lo,
    .frame_error_detect_en, .enhanced_buffer_en, .wr_stb, .wr_in, .rd_stb,
    .rd_data, .rd_valid, .tx_full, .tx_empty, .rx_full, .rx_empty,
    .frame_error_flag, .frame_error_clr, .rx_overflow_flag, .rx_overflow_clr,
    .sdi, .sdo, .bclk_o, .bclk_oe_n, .wclk_i(wclk), .wclk_o, .wclk_oe_n
  );
  apsp_codec_model codec (.bit_clk(cbclk), .wclk, .sdi, .sdo, .run, .ch_len, .tx_word, .rx_l, .rx_r);

  // Link clock from the codec, or looped back from the device as master
  assign bit_clk = master_select ? bclk_o : cbclk;

  // System clock, 100 MHz
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] exp16(input logic [31:0] w, input logic inv);
    return {16'h0, w[15:0] ^ {16{inv}}};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [31:0] d, input logic [3:0] b);
    step();
    wr_stb = 1'b1;
    wr_in = '{data: d, be: b};
    step();
    wr_stb = 1'b0;
  endtask

  task automatic rd(input logic [31:0] e);
    step();
    rd_stb = 1'b1;
    step();
    rd_stb = 1'b0;
    chk({31'h0, rd_valid}, 32'h1);
    chk(rd_data, e);
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    seed = 22;
    {errors, checks, ch_len, wr_in, run} = '0;
    {resetn, module_en, wr_stb, rd_stb, frame_error_clr, rx_overflow_clr, width_sel_lo} = '0;
    master_select = 1'b0;
    {audio_enable, enhanced_buffer_en, frame_error_detect_en} = 3'h7;
    ch_len = 6'h10;
    tx_word = $random(seed);
    run = 1'b1;
    repeat (10) step();
    resetn = 1'b1;
    step();
    module_en = 1'b1;
    repeat (15) step();
    run = 1'b0;
    smp = $random(seed);
    got = $random(seed);
    wr(smp, 4'hc);
    wr(smp, 4'h1);
    wr(smp, 4'h2);
    wr(got, 4'hf);
    chk({27'h0, bclk_o, bclk_oe_n, wclk_oe_n, tx_empty, rx_empty}, 32'h1d);
    run = 1'b1;
    repeat (2) @(negedge wclk);
    @(negedge bit_clk);
    #1;
    chk(exp16({16'h0, rx_l}, 1'b0), exp16(smp, 1'b0));
    chk(exp16({16'h0, rx_r}, 1'b0), exp16(got, 1'b0));
    repeat (8) step();
    rd(exp16(tx_word, 1'b0));
    rd(exp16(tx_word, 1'b1));
    @(posedge wclk);
    @(negedge bit_clk);
    #1;
    chk({16'h0, rx_l}, 32'h0);
    chk({31'h0, frame_error_flag}, 32'h0);
    ch_len = 6'h8;
    repeat (2) @(negedge wclk);
    ch_len = 6'h10;
    repeat (2) @(negedge wclk);
    #1;
    chk({31'h0, frame_error_flag}, 32'h1);
    step();
    frame_error_clr = 1'b1;
    step();
    frame_error_clr = 1'b0;
    repeat (2) @(negedge wclk);
    #1;
    chk({31'h0, frame_error_flag}, 32'h0);
    chk({29'h0, rx_overflow_flag, rx_full, rx_empty}, 32'h6);
    step();
    rx_overflow_clr = 1'b1;
    step();
    rx_overflow_clr = 1'b0;
    chk({31'h0, rx_overflow_flag}, 32'h0);
    // Leave, flush, then come back as clock master
    module_en = 1'b0;
    repeat (20) step();
    chk({29'h0, tx_empty, rx_empty, rx_full}, 32'h6);
    master_select = 1'b1;
    step();
    module_en = 1'b1;
    @(negedge wclk_o);
    repeat (15) @(negedge bit_clk);
    #1;
    chk({30'h0, bclk_oe_n, wclk_o}, 32'h0);
    @(negedge bit_clk);
    #1;
    chk({30'h0, wclk_oe_n, wclk_o}, 32'h1);
    repeat (10) wr($random(seed), 4'hf);
    chk({31'h0, tx_full}, 32'h1);
    end_of_test();
  end
endmodule
